// *** isa_pkg.sv ***
// Shared constants and types for the I2C slave address match and receive block
package isa_pkg;

  // Slave mode selection (two address widths, with or without start/stop interrupts)
  typedef enum logic [1:0] {
    ISA_MODE_7BIT      = 2'b00,
    ISA_MODE_10BIT     = 2'b01,
    ISA_MODE_7BIT_SP   = 2'b10,
    ISA_MODE_10BIT_SP  = 2'b11
  } isa_mode_t;

  // Receiver state
  typedef enum logic [2:0] {
    ISA_ST_IDLE  = 3'b000,
    ISA_ST_SHIFT = 3'b001,
    ISA_ST_ACK   = 3'b010,
    ISA_ST_ACKHI = 3'b011,
    ISA_ST_IGN   = 3'b100
  } isa_state_t;

  // Byte phase within a transaction
  typedef enum logic [1:0] {
    ISA_PH_ADDR  = 2'b00,
    ISA_PH_ADLO  = 2'b01,
    ISA_PH_DATA  = 2'b10
  } isa_phase_t;

  localparam logic [4:0] ISA_TEN_BIT_HDR = 5'h1e;
  localparam logic [3:0] ISA_BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] ISA_BIT_ZERO = 4'h0;
  localparam int ISA_A9_POS = 2;
  localparam int ISA_A8_POS = 1;
  localparam int ISA_MODE_TEN_POS = 0;
  localparam int ISA_MODE_SP_POS = 1;

endpackage

// *** isa_sync.sv ***
// Two-flop synchroniser with edge detection for one bus line
`timescale 1ns/1ps
module isa_sync (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Line in
  input wire logic line_in,
  // Synchronised level and edges
  output logic level,
  output logic rise,
  output logic fall
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  // Idle bus level is high, so reset to one avoids a false edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      prev_r <= 1'b1;
    end else begin
      meta_r <= line_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level = sync_r;
  assign rise = sync_r & ~prev_r;
  assign fall = ~sync_r & prev_r;

endmodule

// *** isa_slave.sv ***
// I2C slave receive path: address matching, acknowledge control and clock stretching
// Overview of operation
// - Mode input picks 7-bit or 10-bit addressing, each with or without start/stop irq.
// - Start/stop irq modes also flag irq on start, restart and stop.
// - First byte after start compared with primary address; match buffers and flags.
// - Primary mask bits mark address bits that take part in the compare; cleared mask bits are ignored.
// - Secondary 7-bit address with its own mask matches the same way.
// - In 7-bit mode the read/write bit is left out of the compare.
// - 10-bit high byte must be 11110, A9, A8, 0; A9/A8 from address bits 2,1.
// - After acking a 10-bit high write byte, set update flag and hold SCL low.
// - 10-bit low byte compared in full; always flag irq, update and hold SCL.
// - Writing the own address clears the update flag and releases SCL.
// - 10-bit read needs a prior full write match before restart with read.
// - Matching write address clears status read/write, buffers byte and acks.
// - Address is nacked when buffer full or overflow set, unless overwrite enabled.
// - Irq flag set for acked, held and 10-bit low bytes, not for ignored or nacked ones; only software clears it.
// - With stretch enabled SCL is held after each acked byte other than a 10-bit high write byte until release is set.
// - Start-seen and stop-seen status bits follow bus conditions.
// - Buffer full sets on a load and clears when software reads the buffer.
// - Without hold the block acks each data byte that does not overflow and flags irq on its 8th falling edge, as the ack slot starts.
// - With hold, 8th falling edge of matched byte flags irq and holds SCL.
// - Ack-time status tells whether the irq came before or after the ack slot.
// - With hold, software picks the ack level and then releases the clock.
// - With hold, irq after the 9th falling edge on ack, not on nack.
// - Without hold the hardware acks; with hold the software value is sent.
// - Ack-time set after the 8th falling edge, only while a hold is enabled.
// - A restart resets the slave logic just like a start.
`timescale 1ns/1ps
module isa_slave
  import isa_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Bus pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Configuration
  input wire logic [1:0] port_mode_select,
  input wire logic [7:0] own_address_primary,
  input wire logic own_address_primary_wr,
  input wire logic [7:0] own_address_secondary,
  input wire logic [7:0] address_mask_primary,
  input wire logic [7:0] address_mask_secondary,
  input wire logic stretch_enable,
  input wire logic address_hold_enable,
  input wire logic data_hold_enable,
  input wire logic buffer_overwrite_enable,
  input wire logic ack_data_select,
  // Software strobes
  input wire logic clock_release_set,
  input wire logic receive_buffer_rd,
  input wire logic port_irq_clear,
  input wire logic overflow_clear,
  // Status
  output logic [7:0] receive_buffer,
  output logic buffer_full_flag,
  output logic receive_overflow_flag,
  output logic port_irq_flag,
  output logic update_address_flag,
  output logic clock_release_bit,
  output logic ack_time_status,
  output logic read_write_status,
  output logic data_address_status,
  output logic start_seen,
  output logic stop_seen
);

  logic scl_s, scl_rise, scl_fall;
  logic sda_s, sda_rise, sda_fall;

  isa_sync u_scl (.sys_clk(sys_clk), .rst(rst), .line_in(scl_in), .level(scl_s), .rise(scl_rise),
    .fall(scl_fall));
  isa_sync u_sda (.sys_clk(sys_clk), .rst(rst), .line_in(sda_in), .level(sda_s), .rise(sda_rise),
    .fall(sda_fall));

  isa_state_t state_r, state_nxt;
  isa_phase_t phase_r;
  logic [7:0] shift_r;
  logic [3:0] bit_cnt_r;
  logic ack_drive_r;
  logic ten_matched_r;
  logic buf_full_r, ovf_r, irq_r, ua_r, ckp_r, ack_time_status_r, rw_r, da_r, start_r, stop_r;
  logic [7:0] rxbuf_r;
  logic low_pending_r;

  // Address compare helpers
  function automatic logic match7(input logic [7:0] rx, input logic [7:0] own, input logic [7:0] msk);
    match7 = (((rx ^ own) & msk) >> 1) == 8'h00;
  endfunction

  wire isa_mode_t mode = isa_mode_t'(port_mode_select);
  wire ten_bit = (mode == ISA_MODE_10BIT) | (mode == ISA_MODE_10BIT_SP);
  wire sp_irq = port_mode_select[ISA_MODE_SP_POS];
  wire hold_en = address_hold_enable | data_hold_enable;
  wire start_ev = sda_fall & scl_s;
  wire stop_ev = sda_rise & scl_s;
  wire byte_done = (state_r == ISA_ST_SHIFT) && scl_fall && (bit_cnt_r == ISA_BITS_PER_BYTE);
  wire [7:0] rx_byte = shift_r;
  wire hi_pattern = {rx_byte[7:3], rx_byte[0]} == {ISA_TEN_BIT_HDR, 1'b0};
  wire hi_match = (rx_byte[7:3] == ISA_TEN_BIT_HDR) &&
                  (rx_byte[2] == own_address_primary[ISA_A9_POS]) &&
                  (rx_byte[1] == own_address_primary[ISA_A8_POS]);
  wire hi_write_match = hi_match && hi_pattern;
  wire hi_read_match = hi_match && rx_byte[0] && ten_matched_r;
  wire m7 = match7(rx_byte, own_address_primary, address_mask_primary) |
            match7(rx_byte, own_address_secondary, address_mask_secondary);
  wire lo_match = rx_byte == own_address_primary;
  wire overflow = (buf_full_r | ovf_r) & ~buffer_overwrite_enable;
  wire overwrite_ok = buffer_overwrite_enable | ~buf_full_r;
  wire addr_hit = (phase_r == ISA_PH_ADDR) && (ten_bit ? (hi_write_match | hi_read_match) : m7);
  wire lo_byte = phase_r == ISA_PH_ADLO;
  wire data_byte = phase_r == ISA_PH_DATA;
  wire accept = addr_hit | (lo_byte & lo_match) | data_byte;
  wire hw_ack = accept & ~overflow;
  wire hold_now = byte_done && accept &&
                  ((addr_hit & address_hold_enable) | (data_byte & data_hold_enable));
  wire load_buf = byte_done & accept & overwrite_ok;
  wire ack_slot_end = (state_r == ISA_ST_ACK) && scl_fall;
  wire acked = ack_slot_end & ack_drive_r;
  // Raised when the ack slot ends, so the address hold never blocks the ack clock itself
  // High byte only after an ack; low byte always, matched or not
  wire need_ua = ack_slot_end & ten_bit &
                 (((phase_r == ISA_PH_ADLO) & ack_drive_r) | low_pending_r);
  wire hw_hold_ack = acked & stretch_enable & data_byte;
  wire byte_irq = (byte_done & accept & ~hold_now & (hw_ack | lo_byte)) | (byte_done & lo_byte) |
                  (hold_now) | (acked & hold_en);

  // Bit shifting and framing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ISA_ST_IDLE: state_nxt = ISA_ST_IDLE;
      ISA_ST_SHIFT: begin
        if (byte_done) begin
          state_nxt = ((phase_r == ISA_PH_ADDR) & ~addr_hit) ? ISA_ST_IGN : ISA_ST_ACK;
        end
      end
      ISA_ST_ACK: begin
        if (scl_fall) begin
          state_nxt = ack_drive_r ? ISA_ST_SHIFT : ISA_ST_IGN;
        end
      end
      ISA_ST_ACKHI: state_nxt = ISA_ST_SHIFT;
      ISA_ST_IGN: state_nxt = ISA_ST_IGN;
      default: state_nxt = ISA_ST_IDLE;
    endcase
    if (start_ev) begin
      state_nxt = ISA_ST_SHIFT;
    end else if (stop_ev) begin
      state_nxt = ISA_ST_IDLE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= ISA_ST_IDLE;
      phase_r <= ISA_PH_ADDR;
      shift_r <= 8'h00;
      bit_cnt_r <= ISA_BIT_ZERO;
      ack_drive_r <= 1'b0;
      ten_matched_r <= 1'b0;
      low_pending_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (start_ev) begin
        phase_r <= ISA_PH_ADDR;
        bit_cnt_r <= ISA_BIT_ZERO;
        ack_drive_r <= 1'b0;
      end else if (stop_ev) begin
        ack_drive_r <= 1'b0;
        ten_matched_r <= 1'b0;
      end else begin
        if (state_r == ISA_ST_SHIFT && scl_rise) begin
          shift_r <= {shift_r[6:0], sda_s};
          bit_cnt_r <= bit_cnt_r + 4'h1;
        end
        if (byte_done) begin
          bit_cnt_r <= ISA_BIT_ZERO;
          // Hold mode waits for software; the choice is latched on release
          ack_drive_r <= hold_now ? 1'b0 : hw_ack;
          if (ten_bit && phase_r == ISA_PH_ADDR && hi_read_match) begin
            phase_r <= ISA_PH_DATA;
          end else if (ten_bit && phase_r == ISA_PH_ADDR && hi_write_match) begin
            phase_r <= ISA_PH_ADLO;
          end else if (lo_byte) begin
            ten_matched_r <= lo_match;
            low_pending_r <= 1'b1;
            phase_r <= lo_match ? ISA_PH_DATA : ISA_PH_ADDR;
          end else if (addr_hit) begin
            phase_r <= ISA_PH_DATA;
          end
        end
        if (hold_en && clock_release_set && ack_time_status_r) begin
          ack_drive_r <= ~ack_data_select;
        end
        if (ack_slot_end) begin
          ack_drive_r <= 1'b0;
          low_pending_r <= 1'b0;
        end
      end
    end
  end

  // Status flags; a set in the same cycle as a clear wins, except the release bit, where a hold beats a release
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      buf_full_r <= 1'b0;
      ovf_r <= 1'b0;
      irq_r <= 1'b0;
      ua_r <= 1'b0;
      ckp_r <= 1'b1;
      ack_time_status_r <= 1'b0;
      rw_r <= 1'b0;
      da_r <= 1'b0;
      start_r <= 1'b0;
      stop_r <= 1'b0;
      rxbuf_r <= 8'h00;
    end else begin
      if (load_buf) begin
        rxbuf_r <= rx_byte;
        buf_full_r <= 1'b1;
        da_r <= data_byte;
        if (addr_hit) begin
          rw_r <= rx_byte[0];
        end
      end else if (receive_buffer_rd) begin
        buf_full_r <= 1'b0;
      end
      if (byte_done & accept & ~overwrite_ok) begin
        ovf_r <= 1'b1;
      end else if (overflow_clear) begin
        ovf_r <= 1'b0;
      end
      if (byte_irq | ((start_ev | stop_ev) & sp_irq)) begin
        irq_r <= 1'b1;
      end else if (port_irq_clear) begin
        irq_r <= 1'b0;
      end
      if (need_ua) begin
        ua_r <= 1'b1;
      end else if (own_address_primary_wr) begin
        ua_r <= 1'b0;
      end
      if (hold_now | hw_hold_ack) begin
        ckp_r <= 1'b0;
      end else if (clock_release_set) begin
        ckp_r <= 1'b1;
      end
      if (hold_now & hold_en) begin
        ack_time_status_r <= 1'b1;
      end else if (ack_slot_end | start_ev | stop_ev) begin
        ack_time_status_r <= 1'b0;
      end
      if (start_ev) begin
        start_r <= 1'b1;
        stop_r <= 1'b0;
      end else if (stop_ev) begin
        stop_r <= 1'b1;
        start_r <= 1'b0;
      end
    end
  end

  // SCL held low while release bit clear or address update pending
  // Only pulled while SCL is already low, so a master high phase is never cut short
  wire scl_hold = (~ckp_r | ua_r) & ~scl_s;
  wire hold_pending = ack_time_status_r & ~ckp_r;
  wire sda_ack = (state_r == ISA_ST_ACK) & ack_drive_r & ~hold_pending;

  assign scl_out = 1'b0;
  assign scl_oe = scl_hold;
  assign sda_out = 1'b0;
  assign sda_oe = sda_ack;
  assign receive_buffer = rxbuf_r;
  assign buffer_full_flag = buf_full_r;
  assign receive_overflow_flag = ovf_r;
  assign port_irq_flag = irq_r;
  assign update_address_flag = ua_r;
  assign clock_release_bit = ckp_r;
  assign ack_time_status = ack_time_status_r;
  assign read_write_status = rw_r;
  assign data_address_status = da_r;
  assign start_seen = start_r;
  assign stop_seen = stop_r;

endmodule

// *** isa_slave_checker.sv ***
// Concurrent checks on the I2C slave receive ports
`timescale 1ns/1ps
module isa_slave_checker (
  // Clock and reset
  input logic sys_clk,
  input logic rst,
  // Controls
  input logic [1:0] port_mode_select,
  input logic own_address_primary_wr,
  input logic buffer_overwrite_enable,
  input logic address_hold_enable,
  input logic data_hold_enable,
  input logic clock_release_set,
  input logic receive_buffer_rd,
  input logic port_irq_clear,
  // Bus drives and status
  input logic sda_oe,
  input logic scl_oe,
  input logic buffer_full_flag,
  input logic receive_overflow_flag,
  input logic port_irq_flag,
  input logic update_address_flag,
  input logic clock_release_bit,
  input logic ack_time_status,
  input logic start_seen
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  irq_sticky_a: assert property (port_irq_flag && !port_irq_clear |=> port_irq_flag)
    else $error("irq flag dropped without software clear");
  bf_read_a: assert property (receive_buffer_rd |=> !buffer_full_flag)
    else $error("buffer full kept after read");
  ua_clear_a: assert property (own_address_primary_wr |=> !update_address_flag)
    else $error("update flag kept after address write");
  release_a: assert property (clock_release_set |=> clock_release_bit)
    else $error("clock release not taken");
  scl_free_a: assert property (clock_release_bit && !update_address_flag |-> !scl_oe)
    else $error("SCL held while released");
  scl_hold_a: assert property ($fell(clock_release_bit) |-> ##[0:3] scl_oe)
    else $error("SCL not held after clock release cleared");
  ovf_nack_a: assert property ($rose(sda_oe) |-> buffer_overwrite_enable || !$past(receive_overflow_flag))
    else $error("ack given during overflow");
  hw_ack_irq_a: assert property ($fell(sda_oe) && !address_hold_enable && !data_hold_enable |-> port_irq_flag)
    else $error("no irq after hardware ack");
  ack_time_a: assert property ($rose(ack_time_status) |-> address_hold_enable || data_hold_enable)
    else $error("ack time raised without hold");
  start_irq_a: assert property ($rose(start_seen) && port_mode_select[1] |-> ##[0:2] port_irq_flag)
    else $error("no irq on start");
endmodule

bind isa_slave isa_slave_checker chk (.*);

// *** isa_master_model.sv ***
// Behavioural I2C master: pulls SCL/SDA low or lets them float high
`timescale 1ns/1ps
module isa_master_model (
  // Resolved bus
  input logic scl,
  input logic sda,
  // Pull-low drives and stall flag
  output logic scl_lo,
  output logic sda_lo,
  output logic hung
);
  initial begin
    scl_lo = 0;
    sda_lo = 0;
    hung = 0;
  end
  // Slave may stretch; give up after 20 us rather than hang
  task automatic scl_up();
    scl_lo = 0;
    for (int n = 0; !scl && n < 2000; n++) #10;
    hung = !scl;
    #31.25;
  endtask
  task automatic clk_bit(input logic b, output logic s);
    sda_lo = !b;
    #31.25;
    scl_up();
    s = sda;
    #31.25;
    scl_lo = 1;
    #31.25;
  endtask
  task automatic bits8(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
  endtask
  task automatic ack_slot(output logic acked);
    logic s;
    clk_bit(1, s);
    acked = !s;
  endtask
  // Also serves as a restart
  task automatic start();
    sda_lo = 0;
    #31.25;
    scl_up();
    sda_lo = 1;
    #31.25;
    scl_lo = 1;
    #31.25;
  endtask
  task automatic stop();
    sda_lo = 1;
    #31.25;
    scl_up();
    sda_lo = 0;
    #62.5;
  endtask
endmodule

// *** isa_slave_test.sv ***
// Self-checking bench for the I2C slave receive block
`timescale 1ns/1ps
module isa_slave_test
  import isa_pkg::*;
;
  logic sys_clk, rst, scl_lo, sda_lo, hung, scl_oe, sda_oe, scl_out, sda_out, a;
  logic own_address_primary_wr, stretch_enable, address_hold_enable, data_hold_enable;
  logic buffer_overwrite_enable, ack_data_select, clock_release_set, receive_buffer_rd;
  logic port_irq_clear, overflow_clear, buffer_full_flag, receive_overflow_flag, port_irq_flag;
  logic update_address_flag, clock_release_bit, ack_time_status, read_write_status;
  logic data_address_status, start_seen, stop_seen;
  logic [1:0] port_mode_select;
  logic [7:0] own_address_primary, own_address_secondary, address_mask_primary;
  logic [7:0] address_mask_secondary, receive_buffer;
  logic [7:0] tb_addr [3] = '{8'hae, 8'h28, 8'h66};
  logic tb_ack [3] = '{1'b1, 1'b0, 1'b1};
  int n_errors, check_count;
  wire scl_in = !(scl_lo || scl_oe);
  wire sda_in = !(sda_lo || sda_oe);
  always #5 sys_clk = !sys_clk;
  isa_master_model master (.scl(scl_in), .sda(sda_in), .scl_lo, .sda_lo, .hung);
  isa_slave dut (.*);
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk8({7'h0, g}, {7'h0, e});
  endtask
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic pulse(ref logic s);
    @(negedge sys_clk);
    s = 1;
    @(negedge sys_clk);
    s = 0;
  endtask
  task automatic settle();
    repeat (6) @(negedge sys_clk);
  endtask
  task automatic send(input logic [7:0] b);
    master.bits8(b);
    master.ack_slot(a);
    settle();
  endtask
  // Software side of each received byte
  task automatic serve();
    pulse(receive_buffer_rd);
    pulse(port_irq_clear);
    pulse(clock_release_set);
  endtask
  always @(posedge hung) begin
    n_errors++;
    report_and_stop();
  end
  initial begin
    {sys_clk, own_address_primary_wr, stretch_enable, address_hold_enable, data_hold_enable} = 0;
    {buffer_overwrite_enable, ack_data_select, clock_release_set, receive_buffer_rd} = 0;
    {port_irq_clear, overflow_clear, n_errors, check_count} = 0;
    rst = 1;
    port_mode_select = ISA_MODE_7BIT;
    own_address_primary = 8'ha8;
    own_address_secondary = 8'h66;
    address_mask_primary = 8'hfe;
    address_mask_secondary = 8'hfe;
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 0;
    settle();
    stretch_enable = 1;
    master.start();
    settle();
    chk1(start_seen, 1);
    send(8'ha8);
    chk1(a, 1);
    chk8(receive_buffer, 8'ha8);
    chk1(buffer_full_flag, 1);
    chk1(port_irq_flag, 1);
    chk1(read_write_status, 0);
    serve();
    chk1(buffer_full_flag, 0);
    send(8'ha5);
    chk1(a, 1);
    chk8(receive_buffer, 8'ha5);
    chk1(data_address_status, 1);
    chk1(clock_release_bit, 0);
    chk1(scl_out | sda_out, 0);
    serve();
    master.stop();
    settle();
    chk1(stop_seen, 1);
    $display("test stretch done");
    stretch_enable = 0;
    port_mode_select = ISA_MODE_7BIT_SP;
    master.start();
    settle();
    chk1(port_irq_flag, 1);
    pulse(port_irq_clear);
    send(8'h30);
    chk1(a, 0);
    chk1(port_irq_flag, 0);
    master.stop();
    settle();
    chk1(port_irq_flag, 1);
    pulse(port_irq_clear);
    port_mode_select = ISA_MODE_7BIT;
    address_mask_primary = 8'hf0;
    foreach (tb_addr[i]) begin
      master.start();
      send(tb_addr[i]);
      chk1(a, tb_ack[i]);
      serve();
      master.stop();
    end
    settle();
    address_mask_primary = 8'hfe;
    $display("test match done");
    master.start();
    send(8'ha8);
    master.start();
    send(8'ha8);
    chk1(a, 0);
    chk1(receive_overflow_flag, 1);
    serve();
    pulse(overflow_clear);
    chk1(receive_overflow_flag, 0);
    master.start();
    send(8'ha8);
    chk1(a, 1);
    serve();
    $display("test overflow done");
    address_hold_enable = 1;
    for (int s = 0; s < 2; s++) begin
      master.start();
      master.bits8(8'ha8);
      settle();
      chk1(port_irq_flag, 1);
      chk1(clock_release_bit, 0);
      chk1(ack_time_status, 1);
      ack_data_select = s[0];
      serve();
      master.ack_slot(a);
      settle();
      chk1(a, !s[0]);
      chk1(port_irq_flag, !s[0]);
      pulse(port_irq_clear);
    end
    master.stop();
    settle();
    address_hold_enable = 0;
    ack_data_select = 0;
    $display("test hold done");
    port_mode_select = ISA_MODE_10BIT;
    own_address_primary = 8'h02;
    master.start();
    send(8'hf4);
    chk1(a, 0);
    master.start();
    send(8'hf2);
    chk1(a, 1);
    chk1(update_address_flag, 1);
    serve();
    own_address_primary = 8'h3c;
    pulse(own_address_primary_wr);
    chk1(update_address_flag, 0);
    send(8'h3c);
    chk1(a, 1);
    chk1(update_address_flag, 1);
    chk8(receive_buffer, 8'h3c);
    serve();
    own_address_primary = 8'h02;
    pulse(own_address_primary_wr);
    chk1(update_address_flag, 0);
    master.start();
    send(8'hf3);
    chk1(a, 1);
    chk1(read_write_status, 1);
    serve();
    master.stop();
    settle();
    $display("test ten bit done");
    report_and_stop();
  end
endmodule
